// ===== rtl/dual_timer_pkg.sv
package dual_timer_pkg;
  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned RTC_REF_HZ   = 32768;
  localparam int unsigned RTC_DIV      = RTC_REF_HZ;

  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_CTL   = 8'h04;
  localparam logic [7:0] OFS_EN    = 8'h08;
  localparam logic [7:0] OFS_DIS   = 8'h0c;
  localparam logic [7:0] OFS_LOAD  = 8'h10;
  localparam logic [7:0] OFS_MATCH = 8'h14;
  localparam logic [7:0] OFS_VALUE = 8'h18;
  localparam logic [7:0] OFS_CAPT  = 8'h1c;
  localparam logic [7:0] OFS_STAT  = 8'h20;

  localparam int CFG_GM_LSB   = 0;
  localparam int CFG_UP32_BIT = 3;
  localparam int CFG_A_LSB    = 4;
  localparam int CFG_B_LSB    = 8;
  localparam int HF_UP_BIT    = 3;
  localparam int CTL_A_LSB    = 0;
  localparam int CTL_B_LSB    = 8;
  localparam int CT_INV       = 0;
  localparam int CT_HALT      = 1;
  localparam int CT_TRIG      = 2;
  localparam int CT_WAIT      = 3;
  localparam int CT_EDGE_LSB  = 4;
  localparam int EN_A_BIT     = 0;
  localparam int EN_B_BIT     = 1;
  localparam int STAT_RUN_A   = 2;
  localparam int STAT_RUN_B   = 3;
  localparam int STAT_PWM_A   = 4;
  localparam int STAT_PWM_B   = 5;
  localparam int STAT_WIDE    = 6;
  localparam int HTRANS_ACT   = 1;

  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [31:0] CTL_RST   = 32'h0000_0000;
  localparam logic [31:0] LOAD_RST  = 32'hffff_ffff;
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;

  typedef enum logic [2:0] {GM_ONE_SHOT, GM_PERIODIC, GM_RTC, GM_PAIR} glob_mode_e;
  typedef enum logic [2:0] {HM_ONE_SHOT, HM_PERIODIC, HM_EDGE_COUNT, HM_EDGE_TIME,
                            HM_PWM} half_mode_e;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} half_run_e;

  typedef struct packed {
    half_mode_e mode;
    logic       up;
    logic       invert;
    logic       halt_in_debug;
    logic       output_trigger_on;
    logic       wait_chain_start;
    edge_sel_e  edge_sel;
  } half_cfg_s;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_s;

  typedef struct packed {
    half_run_e   st;
    logic [31:0] count;
    logic [31:0] capture;
    logic        timeout;
    logic        pwm;
  } half_state_s;

  typedef struct packed {
    logic prev;
    logic hit;
  } edge_state_s;

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ctl;
    logic [31:0] load;
    logic [31:0] match;
    logic [31:0] hrdata;
    logic [1:0]  en;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        rtc_prev;
    logic [15:0] rtc_cnt;
    logic        rtc_tick;
    logic        trig_a;
    logic        trig_b;
    logic        pin_a;
    logic        pin_a_oe;
    logic        pin_b;
    logic        pin_b_oe;
    logic        hreadyout;
  } top_state_s;

  localparam half_state_s HALF_STATE_RST = '0;
  localparam edge_state_s EDGE_STATE_RST = '0;
  localparam top_state_s  TOP_STATE_RST  = '{cfg: CFG_RST, ctl: CTL_RST, load: LOAD_RST,
                                             match: MATCH_RST, hreadyout: 1'b1,
                                             default: '0};
endpackage

// ===== rtl/edge_pick.sv
`timescale 1ns/100ps
module edge_pick (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_pin,
  input  wire dual_timer_pkg::edge_sel_e i_sel,
  output logic                           o_hit
);
  import dual_timer_pkg::*;

  edge_state_s st_reg;
  edge_state_s st_next;

  always_comb begin
    st_next.prev = i_pin;
    case (i_sel)
      EDGE_RISE: st_next.hit = i_pin && !st_reg.prev;
      EDGE_FALL: st_next.hit = !i_pin && st_reg.prev;
      default:   st_next.hit = i_pin ^ st_reg.prev;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg <= EDGE_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_hit = st_reg.hit;
endmodule

// ===== rtl/timer_half.sv
`timescale 1ns/100ps
module timer_half (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_n,
  input  wire dual_timer_pkg::half_cfg_s i_cfg,
  input  wire logic                      i_wide,
  input  wire logic                      i_enable,
  input  wire logic                      i_tick,
  input  wire logic                      i_edge,
  input  wire logic                      i_start,
  input  wire logic [31:0]               i_load,
  input  wire logic [31:0]               i_match,
  output logic [31:0]                    o_count,
  output logic [31:0]                    o_capture,
  output logic                           o_timeout,
  output logic                           o_pwm,
  output logic                           o_running
);
  import dual_timer_pkg::*;

  half_state_s st_reg;
  half_state_s st_next;
  logic [31:0] mask;
  logic [31:0] load;
  logic [31:0] match;
  logic [31:0] term;
  logic [31:0] reload;
  logic [31:0] step;
  logic        down;
  logic        os_sel;
  logic        per_sel;
  logic        inv;

  always_comb begin
    mask    = i_wide ? 32'hffff_ffff : 32'h0000_ffff;
    load    = i_load & mask;
    match   = i_match & mask;
    os_sel  = i_cfg.mode == HM_ONE_SHOT;
    per_sel = i_cfg.mode == HM_PERIODIC || i_cfg.mode == HM_PWM;
    inv     = i_cfg.invert;
    // PWM always counts down so the edge lands at the reload
    down    = !i_cfg.up || i_cfg.mode == HM_PWM;
    step    = (down ? st_reg.count - 32'h1 : st_reg.count + 32'h1) & mask;
    reload  = down ? load : 32'h0;
    term    = (i_cfg.mode == HM_EDGE_COUNT) ? match : (down ? 32'h0 : load);
    st_next = st_reg;
    st_next.timeout = 1'b0;
    case (st_reg.st)
      ST_IDLE: begin
        if (i_enable) begin
          st_next.count = reload;
          st_next.st = i_cfg.wait_chain_start ? ST_ARMED : ST_RUN;
        end
      end
      ST_ARMED: begin
        if (i_start) begin
          st_next.st = ST_RUN;
        end
      end
      ST_RUN: begin
        case (i_cfg.mode)
          HM_EDGE_COUNT: begin
            if (i_edge && i_tick) begin
              st_next.count = (st_reg.count == term) ? reload : step;
              st_next.timeout = st_reg.count == term;
            end
          end
          HM_EDGE_TIME: begin
            if (i_tick) begin
              st_next.count = step;
            end
            if (i_edge) begin
              st_next.capture = st_reg.count;
              st_next.timeout = 1'b1;
            end
          end
          default: begin
            if (i_tick && st_reg.count == term) begin
              st_next.timeout = 1'b1;
              if (os_sel) begin
                st_next.st = ST_DONE;
              end else begin
                st_next.count = reload;
              end
            end else if (i_tick) begin
              st_next.count = step;
            end
          end
        endcase
      end
      ST_DONE: begin
        st_next.st = ST_DONE;
      end
      default: begin
        st_next.st = ST_IDLE;
      end
    endcase
    if (!i_enable) begin
      st_next.st = ST_IDLE;
      st_next.timeout = 1'b0;
    end
    st_next.pwm = ((st_reg.st == ST_RUN) && (st_reg.count > match)) ^ inv;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg <= HALF_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_count   = st_reg.count;
  assign o_capture = st_reg.capture;
  assign o_timeout = st_reg.timeout;
  assign o_pwm     = st_reg.pwm;
  assign o_running = st_reg.st == ST_RUN;

  property p_hold_no_tick;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.st == ST_RUN && !i_tick) |=> $stable(st_reg.count);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick)
    else $error("count moved without a tick");

  property p_oneshot_stop;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.timeout && $past(os_sel)) |-> (st_reg.st == ST_DONE);
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop)
    else $error("one-shot kept running after timeout");

  property p_periodic_go;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.timeout && $past(per_sel)) |-> (st_reg.st == ST_RUN && st_reg.count == $past(reload));
  endproperty
  a_periodic_go: assert property (p_periodic_go)
    else $error("periodic timer did not reload");

  property p_wait_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.st == ST_ARMED && i_enable && !i_start) |=> (st_reg.st == ST_ARMED);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("armed half started without trigger");

  property p_idle_level;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.st != ST_RUN) |=> (st_reg.pwm == $past(inv));
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle pwm level ignores polarity");
endmodule

// ===== rtl/dual_half_timer_module.sv
`timescale 1ns/100ps
module dual_half_timer_module #(
  parameter int unsigned RTC_DIV_P = dual_timer_pkg::RTC_DIV
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  input  wire dual_timer_pkg::ahb_req_s i_ahb,
  output logic [31:0]                   o_hrdata,
  output logic                          o_hreadyout,
  output logic                          o_hresp,
  input  wire logic                     i_debug_halt,
  input  wire logic                     i_chain_trig,
  input  wire logic                     i_rtc_ref,
  input  wire logic                     i_cap_pin_a,
  output logic                          o_cap_pin_a,
  output logic                          o_cap_pin_a_oe,
  input  wire logic                     i_cap_pin_b,
  output logic                          o_cap_pin_b,
  output logic                          o_cap_pin_b_oe,
  output logic                          o_trig_a,
  output logic                          o_trig_b
);
  import dual_timer_pkg::*;

  localparam logic [15:0] RTC_LAST = 16'(RTC_DIV_P - 1);

  function automatic half_cfg_s half_cfg(input logic [3:0] mode_bits,
                                         input logic [7:0] ctl_bits);
    half_cfg_s c;
    c.mode              = half_mode_e'(mode_bits[2:0]);
    c.up                = mode_bits[HF_UP_BIT];
    c.invert            = ctl_bits[CT_INV];
    c.halt_in_debug     = ctl_bits[CT_HALT];
    c.output_trigger_on = ctl_bits[CT_TRIG];
    c.wait_chain_start  = ctl_bits[CT_WAIT];
    c.edge_sel          = edge_sel_e'(ctl_bits[CT_EDGE_LSB +: 2]);
    return c;
  endfunction

  top_state_s  st_reg;
  top_state_s  st_next;
  glob_mode_e  gm;
  logic        wide;
  logic        rtc_mode;
  half_cfg_s   cfg_a;
  half_cfg_s   cfg_b;
  logic        pwm_sel_a;
  logic        trig_on_a;
  logic        tick_a;
  logic        tick_b;
  logic        en_a;
  logic        en_b;
  logic        addr_ok;
  logic        hit_a;
  logic        hit_b;
  logic [31:0] count_a;
  logic [31:0] count_b;
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic        to_a;
  logic        to_b;
  logic        pwm_a;
  logic        pwm_b;
  logic        run_a;
  logic        run_b;
  logic [31:0] load_b;
  logic [31:0] match_b;
  logic [31:0] stat;

  always_comb begin
    st_next  = st_reg;
    gm       = glob_mode_e'(st_reg.cfg[CFG_GM_LSB +: 3]);
    wide     = gm != GM_PAIR;
    rtc_mode = gm == GM_RTC;
    cfg_a    = half_cfg(st_reg.cfg[CFG_A_LSB +: 4], st_reg.ctl[CTL_A_LSB +: 8]);
    cfg_b    = half_cfg(st_reg.cfg[CFG_B_LSB +: 4], st_reg.ctl[CTL_B_LSB +: 8]);
    if (wide) begin
      // The first half's control byte steers the joined counter
      cfg_a.mode = (gm == GM_ONE_SHOT) ? HM_ONE_SHOT : HM_PERIODIC;
      cfg_a.up   = rtc_mode || st_reg.cfg[CFG_UP32_BIT];
    end
    pwm_sel_a = !wide && cfg_a.mode == HM_PWM;
    trig_on_a = cfg_a.output_trigger_on;
    en_a      = st_reg.en[EN_A_BIT];
    en_b      = !wide && st_reg.en[EN_B_BIT];
    tick_a    = !(cfg_a.halt_in_debug && i_debug_halt)
                && (!rtc_mode || st_reg.rtc_tick);
    tick_b    = !(cfg_b.halt_in_debug && i_debug_halt);
    load_b    = {16'h0000, st_reg.load[31:16]};
    match_b   = {16'h0000, st_reg.match[31:16]};

    // Reference edges are divided to one pulse per second
    st_next.rtc_prev = i_rtc_ref;
    st_next.rtc_tick = 1'b0;
    if (!rtc_mode || !en_a) begin
      st_next.rtc_cnt = 16'h0000;
    end else if (i_rtc_ref && !st_reg.rtc_prev) begin
      if (st_reg.rtc_cnt == RTC_LAST) begin
        st_next.rtc_cnt  = 16'h0000;
        st_next.rtc_tick = 1'b1;
      end else begin
        st_next.rtc_cnt = st_reg.rtc_cnt + 16'h0001;
      end
    end

    st_next.trig_a   = to_a && trig_on_a;
    st_next.trig_b   = to_b && cfg_b.output_trigger_on && !wide;
    st_next.pin_a    = pwm_a;
    st_next.pin_a_oe = pwm_sel_a && en_a;
    st_next.pin_b    = pwm_b;
    st_next.pin_b_oe = cfg_b.mode == HM_PWM && en_b;

    stat = 32'h0000_0000;
    stat[EN_B_BIT:EN_A_BIT] = st_reg.en;
    stat[STAT_RUN_A] = run_a;
    stat[STAT_RUN_B] = run_b;
    stat[STAT_PWM_A] = pwm_a;
    stat[STAT_PWM_B] = pwm_b;
    stat[STAT_WIDE]  = wide;

    // Zero-wait slave: read data is latched at the address phase
    addr_ok = i_ahb.hsel && i_ahb.htrans[HTRANS_ACT] && i_ahb.hready;
    st_next.hreadyout = 1'b1;
    st_next.wr_pend   = addr_ok && i_ahb.hwrite;
    st_next.wr_addr   = i_ahb.haddr[7:0];
    if (addr_ok && !i_ahb.hwrite) begin
      case (i_ahb.haddr[7:0])
        OFS_CFG:   st_next.hrdata = st_reg.cfg;
        OFS_CTL:   st_next.hrdata = st_reg.ctl;
        OFS_EN:    st_next.hrdata = {30'h0, st_reg.en};
        OFS_LOAD:  st_next.hrdata = st_reg.load;
        OFS_MATCH: st_next.hrdata = st_reg.match;
        OFS_VALUE: st_next.hrdata = wide ? count_a : {count_b[15:0], count_a[15:0]};
        OFS_CAPT:  st_next.hrdata = {cap_b[15:0], cap_a[15:0]};
        OFS_STAT:  st_next.hrdata = stat;
        default:   st_next.hrdata = 32'h0000_0000;
      endcase
    end

    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        OFS_CFG: begin
          // Clears both enables, so software must enable after configuring
          st_next.cfg = i_ahb.hwdata;
          st_next.en  = 2'b00;
        end
        OFS_CTL: begin
          st_next.ctl = i_ahb.hwdata;
        end
        OFS_EN: begin
          st_next.en = st_reg.en | i_ahb.hwdata[EN_B_BIT:EN_A_BIT];
        end
        OFS_DIS: begin
          st_next.en = st_reg.en & ~i_ahb.hwdata[EN_B_BIT:EN_A_BIT];
        end
        OFS_LOAD: begin
          st_next.load = i_ahb.hwdata;
        end
        OFS_MATCH: begin
          st_next.match = i_ahb.hwdata;
        end
        default: begin
          st_next.ctl = st_reg.ctl;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg <= TOP_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  edge_pick u_edge_a (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_cap_pin_a),
    .i_sel     (cfg_a.edge_sel),
    .o_hit     (hit_a)
  );

  edge_pick u_edge_b (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_cap_pin_b),
    .i_sel     (cfg_b.edge_sel),
    .o_hit     (hit_b)
  );

  timer_half u_half_a (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_cfg     (cfg_a),
    .i_wide    (wide),
    .i_enable  (en_a),
    .i_tick    (tick_a),
    .i_edge    (hit_a),
    .i_start   (i_chain_trig),
    .i_load    (st_reg.load),
    .i_match   (st_reg.match),
    .o_count   (count_a),
    .o_capture (cap_a),
    .o_timeout (to_a),
    .o_pwm     (pwm_a),
    .o_running (run_a)
  );

  timer_half u_half_b (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_cfg     (cfg_b),
    .i_wide    (1'b0),
    .i_enable  (en_b),
    .i_tick    (tick_b),
    .i_edge    (hit_b),
    .i_start   (to_a),
    .i_load    (load_b),
    .i_match   (match_b),
    .o_count   (count_b),
    .o_capture (cap_b),
    .o_timeout (to_b),
    .o_pwm     (pwm_b),
    .o_running (run_b)
  );

  assign o_hrdata       = st_reg.hrdata;
  assign o_hreadyout    = st_reg.hreadyout;
  assign o_hresp        = 1'b0;
  assign o_cap_pin_a    = st_reg.pin_a;
  assign o_cap_pin_a_oe = st_reg.pin_a_oe;
  assign o_cap_pin_b    = st_reg.pin_b;
  assign o_cap_pin_b_oe = st_reg.pin_b_oe;
  assign o_trig_a       = st_reg.trig_a;
  assign o_trig_b       = st_reg.trig_b;

  property p_cfg_clears_en;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.wr_pend && st_reg.wr_addr == OFS_CFG) |=> (st_reg.en == 2'b00) ##1 !run_a;
  endproperty
  a_cfg_clears_en: assert property (p_cfg_clears_en)
    else $error("configuration write left a half enabled");

  property p_enable_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.wr_pend && st_reg.wr_addr == OFS_EN && i_ahb.hwdata[EN_A_BIT])
      |=> st_reg.en[EN_A_BIT];
  endproperty
  a_enable_set: assert property (p_enable_set)
    else $error("enable write did not enable the first half");

  property p_disable_clr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_reg.wr_pend && st_reg.wr_addr == OFS_DIS && i_ahb.hwdata[EN_B_BIT])
      |=> !st_reg.en[EN_B_BIT] ##1 !run_b;
  endproperty
  a_disable_clr: assert property (p_disable_clr)
    else $error("disable write did not stop the second half");

  property p_trig_gated;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    st_reg.trig_a |-> $past(trig_on_a);
  endproperty
  a_trig_gated: assert property (p_trig_gated)
    else $error("trigger asserted while its enable was clear");

  property p_pin_drive;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    st_reg.pin_a_oe |-> $past(pwm_sel_a);
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("capture pin driven outside PWM mode");

  property p_rtc_only;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    st_reg.rtc_tick |-> $past(rtc_mode);
  endproperty
  a_rtc_only: assert property (p_rtc_only)
    else $error("seconds tick outside real-time-clock mode");

  property p_wide_b_off;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wide |=> !run_b && !st_reg.trig_b;
  endproperty
  a_wide_b_off: assert property (p_wide_b_off)
    else $error("second half active in a 32-bit mode");
endmodule

// ===== test/dual_half_timer_module_test.sv
`timescale 1ns/100ps
module dual_half_timer_module_test;
  import dual_timer_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  ahb_req_s    q = '0;
  ahb_req_s    i_ahb;
  logic [31:0] o_hrdata;
  logic        o_hreadyout, o_hresp;
  logic        i_debug_halt = 1'b0;
  logic        i_chain_trig = 1'b0;
  logic        i_rtc_ref = 1'b0;
  logic        i_cap_pin_a = 1'b0;
  logic        i_cap_pin_b = 1'b0;
  logic        o_cap_pin_a, o_cap_pin_a_oe, o_cap_pin_b, o_cap_pin_b_oe;
  logic        o_trig_a, o_trig_b;
  logic [31:0] v, w;
  int          fail_count = 0, checks_done = 0, cyc = 0, trig_n = 0, trig_m = 0;

  // One slave only, so its ready is the bus ready
  assign i_ahb = {q[$bits(ahb_req_s)-1:1], o_hreadyout};

  dual_half_timer_module #(.RTC_DIV_P(4)) dual_half_timer_module_i (
    .i_sys_clk, .i_rst_n, .i_ahb, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_debug_halt, .i_chain_trig, .i_rtc_ref, .i_cap_pin_a, .o_cap_pin_a,
    .o_cap_pin_a_oe, .i_cap_pin_b, .o_cap_pin_b, .o_cap_pin_b_oe,
    .o_trig_a, .o_trig_b);

  initial forever #4 i_sys_clk = ~i_sys_clk;

  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (o_trig_a === 1'b1)
      trig_n <= trig_n + 1;
    if (o_trig_b === 1'b1)
      trig_m <= trig_m + 1;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic w8(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic xfer(input logic wt, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    q <= '{1'b1, {24'h0, a}, 2'h2, wt, 3'h2, 32'h0, 1'b0};
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    q <= '{1'b0, {24'h0, a}, 2'h0, wt, 3'h2, d, 1'b0};
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
    chk(o_hresp, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  // Configure first, then enable, as software must
  task automatic go(input logic [31:0] c, t, l, m, e);
    wr(OFS_CFG, c);
    wr(OFS_CTL, t);
    wr(OFS_LOAD, l);
    wr(OFS_MATCH, m);
    wr(OFS_EN, e);
  endtask

  initial begin
    w8(5);
    i_rst_n <= 1'b1;
    w8(1);
    rd(OFS_LOAD, v);
    chk(v, LOAD_RST);
    rd(8'h40, v);
    chk(v, 32'h0);
    go(32'h103, 32'h0, 32'h0005_0003, 32'h0, 32'h3);
    w8(30);
    rd(OFS_VALUE, v);
    rd(OFS_VALUE, w);
    chk(v[15:0], 16'h0);
    chk(v[31:16] <= 16'h5 && w[31:16] != v[31:16], 1'b1);
    rd(OFS_STAT, v);
    chk(v[3:0], 4'hb);
    wr(OFS_DIS, 32'h2);
    rd(OFS_STAT, v);
    chk(v[1:0], 2'h1);
    wr(OFS_CFG, 32'h103);
    rd(OFS_STAT, v);
    chk(v[1:0], 2'h0);
    rd(OFS_CFG, v);
    chk(v, 32'h103);
    for (int t = 0; t < 2; t++) begin
      trig_n = 0;
      trig_m = 0;
      go(32'h3, t * 32'h404, 32'h0003_0003, 32'h0, 32'h3);
      w8(20);
      chk(trig_n, t);
      chk(trig_m, t);
    end
    i_debug_halt <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      go(32'h3, h << CT_HALT, 32'h64, 32'h0, 32'h1);
      w8(5);
      rd(OFS_VALUE, v);
      rd(OFS_VALUE, w);
      chk(v[15:0] == w[15:0], h);
    end
    i_debug_halt <= 1'b0;
    go(32'h3, 32'h1 << CT_WAIT, 32'h64, 32'h0, 32'h1);
    w8(10);
    rd(OFS_STAT, v);
    chk(v[STAT_RUN_A], 1'b0);
    i_chain_trig <= 1'b1;
    w8(1);
    i_chain_trig <= 1'b0;
    w8(3);
    rd(OFS_STAT, v);
    chk(v[STAT_RUN_A], 1'b1);
    for (int p = 0; p < 2; p++) begin
      go(32'h443, p * 32'h101, 32'h000a_000a, 32'hffff_ffff, 32'h3);
      w8(5);
      chk(o_cap_pin_a_oe, 1'b1);
      chk(o_cap_pin_a, p[0]);
      chk(o_cap_pin_b_oe, 1'b1);
      chk(o_cap_pin_b, p[0]);
    end
    for (int e = 0; e < 3; e++) begin
      go(32'ha3, e << CT_EDGE_LSB, 32'h0, 32'h64, 32'h1);
      w8(3);
      repeat (3) begin
        i_cap_pin_a <= 1'b1;
        w8(3);
        i_cap_pin_a <= 1'b0;
        w8(3);
      end
      w8(3);
      rd(OFS_VALUE, v);
      chk(v[15:0], (e == 2) ? 16'h6 : 16'h3);
    end
    // Edge time: the capture holds a count taken before the later free-running value
    go(32'hb3, 32'h0, 32'h0, 32'h0, 32'h1);
    w8(4);
    i_cap_pin_a <= 1'b1;
    w8(4);
    i_cap_pin_a <= 1'b0;
    rd(OFS_CAPT, v);
    rd(OFS_VALUE, w);
    chk(v[15:0] != 16'h0 && v[15:0] < w[15:0], 1'b1);
    go(32'h2, 32'h0, 32'hffff_ffff, 32'h0, 32'h1);
    w8(3);
    repeat (8) begin
      i_rtc_ref <= 1'b1;
      w8(2);
      i_rtc_ref <= 1'b0;
      w8(2);
    end
    w8(4);
    rd(OFS_VALUE, v);
    chk(v, 32'h2);
    rd(OFS_STAT, v);
    chk(v[STAT_WIDE], 1'b1);
    // Borrow across bit 16 shows the halves act as one counter
    go(32'h0, 32'h0, 32'h0001_0003, 32'h0, 32'h1);
    w8(10);
    rd(OFS_VALUE, v);
    chk(v[31:16] == 16'h0 && v[15:0] > 16'hff00, 1'b1);
    finish_test();
  end
endmodule
